/* File: pkg/nabc_pkg.sv */
// Constants, field layout and operation codes of the nibble ALU block
package nabc_pkg;

   localparam int NIB_W = 4;
   localparam int FLAG_W = 5;

   // Operations presented by the instruction sequencer
   typedef enum logic [3:0] {
      NABC_ADD_OP               = 4'h0,
      ADD_WITH_CARRY_OP         = 4'h1,
      NABC_SUBTRACT_OP          = 4'h2,
      DIFFERENCE_WITH_BORROW_OP = 4'h3,
      NABC_OR_OP                = 4'h4,
      NABC_AND_OP               = 4'h5,
      NABC_XOR_OP               = 4'h6,
      SKIP_IF_BITS_SET          = 4'h7,
      SKIP_IF_BITS_CLEAR        = 4'h8,
      SKIP_IF_EQUAL             = 4'h9,
      SKIP_IF_UNEQUAL           = 4'hA,
      SKIP_IF_GREATER_EQUAL     = 4'hB,
      SKIP_IF_LESS              = 4'hC,
      ROTATE_RIGHT_THROUGH_CARRY = 4'hD
   } nabc_op_t;

   // Register byte offsets on the Avalon slave
   localparam logic [3:0] STATUS_WORD_OFS = 4'h0;
   localparam logic [3:0] RESULT_OFS      = 4'h4;

   // Status word field positions
   localparam int INDEX_EN_BIT = 0;
   localparam int ZERO_BIT = 1;
   localparam int CARRY_BIT = 2;
   localparam int COMPARE_BIT = 3;
   localparam int BCD_BIT = 4;
   localparam logic [FLAG_W-1:0] STATUS_WORD_RST = 5'h00;

   // Result register field positions
   localparam int RES_SKIP_BIT = 4;
   localparam int RES_CARRY_BIT = 5;
   localparam logic [5:0] RESULT_RST = 6'h00;

   // Decimal correction thresholds
   localparam logic [4:0] DEC_TEN      = 5'h0A;
   localparam logic [4:0] DEC_TWENTY   = 5'h14;
   localparam logic [4:0] DEC_28       = 5'h1C;
   localparam logic [4:0] DEC_29       = 5'h1D;
   localparam logic [3:0] DEC_NINE     = 4'h9;
   localparam logic [3:0] DEC_SIX      = 4'h6;
   localparam logic [1:0] DEC_ROT_TWO  = 2'h2;
   localparam logic [1:0] DEC_HI_LOW   = 2'h2;
   localparam logic [1:0] DEC_HI_HIGH  = 2'h3;

endpackage : nabc_pkg

/* File: verilog/nabc_alu.sv */
// Nibble ALU with decimal correction, skip judgements and Avalon status access
//
// Chosen here: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none

module nabc_alu #(
   parameter int MEM_ADDR_W = 7
) (
   input  wire logic                        SYS_CLK,
   input  wire logic                        RST_N,
   input  wire logic                        OP_VALID,
   input  wire nabc_pkg::nabc_op_t          OP_CODE,
   input  wire logic [nabc_pkg::NIB_W-1:0]  OPERAND_FIRST,
   input  wire logic [nabc_pkg::NIB_W-1:0]  OPERAND_SECOND,
   input  wire logic                        FIRST_IS_MEM,
   input  wire logic [MEM_ADDR_W-1:0]       MEM_ADDR_IN,
   input  wire logic [MEM_ADDR_W-1:0]       INDEX_IN,
   output logic                             WB_REG_WE,
   output logic                             WB_MEM_WE,
   output logic [nabc_pkg::NIB_W-1:0]       WB_DATA,
   output logic [MEM_ADDR_W-1:0]            WB_MEM_ADDR,
   output logic                             SKIP_NEXT,
   output logic                             OP_DONE,
   output logic [nabc_pkg::FLAG_W-1:0]      STATUS_FLAGS,
   input  wire logic [3:0]                  AVS_ADDRESS,
   input  wire logic                        AVS_READ,
   input  wire logic                        AVS_WRITE,
   input  wire logic [31:0]                 AVS_WRITEDATA,
   input  wire logic [3:0]                  AVS_BYTEENABLE,
   output logic [31:0]                      AVS_READDATA,
   output logic                             AVS_WAITREQUEST
);
   import nabc_pkg::*;

   // Address width beyond 16 bits has no use on this core
   if (MEM_ADDR_W < 1 || MEM_ADDR_W > 16) begin : g_bad_addr_w
      $error("MEM_ADDR_W out of range");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Decimal correction and index modification functions

   function automatic logic [4:0] dec_add_fix(input logic [4:0] s);
      logic [1:0] hi;
      hi = DEC_HI_HIGH;
      if (s < DEC_TEN) begin
         dec_add_fix = {1'b0, s[3:0]};
      end else if (s < DEC_TWENTY) begin
         dec_add_fix = {1'b1, 4'(s - DEC_TEN)};
      end else begin
         if (s == DEC_28 || s == DEC_29) begin
            hi = DEC_HI_LOW;
         end
         dec_add_fix = {1'b1, hi, 2'(s[1:0] + DEC_ROT_TWO)};
      end
   endfunction : dec_add_fix

   function automatic logic [4:0] dec_sub_fix(input logic [4:0] d);
      if (!d[4] && d[3:0] <= DEC_NINE) begin
         dec_sub_fix = {1'b0, d[3:0]};
      end else if (d[4] && d[3:0] >= DEC_SIX) begin
         dec_sub_fix = {1'b1, 4'(d[3:0] - DEC_SIX)};
      end else begin
         dec_sub_fix = {1'b1, DEC_HI_HIGH, 2'(d[1:0] + DEC_ROT_TWO)};
      end
   endfunction : dec_sub_fix

   function automatic logic [MEM_ADDR_W-1:0] idx_mod(input logic en,
                                                     input logic [MEM_ADDR_W-1:0] a,
                                                     input logic [MEM_ADDR_W-1:0] ix);
      idx_mod = en ? MEM_ADDR_W'(a + ix) : a;
   endfunction : idx_mod

   ////////////////////////////////////////////////////////////////////////////
   // Operand stage

   logic                   stage_valid;
   nabc_op_t               stage_op;
   logic [NIB_W-1:0]       temp_a;
   logic [NIB_W-1:0]       temp_b;
   logic                   stage_first_mem;
   logic [MEM_ADDR_W-1:0]  stage_addr;
   logic                   next_stage_valid;
   nabc_op_t               next_stage_op;
   logic [NIB_W-1:0]       next_temp_a;
   logic [NIB_W-1:0]       next_temp_b;
   logic                   next_stage_first_mem;
   logic [MEM_ADDR_W-1:0]  next_stage_addr;

   logic [FLAG_W-1:0]      flags;

   always_comb begin
      next_stage_valid = OP_VALID;
      next_stage_op = OP_CODE;
      next_temp_a = temp_a;
      next_temp_b = temp_b;
      next_stage_first_mem = stage_first_mem;
      next_stage_addr = stage_addr;
      if (OP_VALID) begin
         next_temp_a = OPERAND_FIRST;
         next_temp_b = OPERAND_SECOND;
         // Rotate only ever addresses the general register
         next_stage_first_mem = FIRST_IS_MEM &&
                                (OP_CODE != ROTATE_RIGHT_THROUGH_CARRY);
         next_stage_addr = idx_mod(flags[INDEX_EN_BIT], MEM_ADDR_IN, INDEX_IN);
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         stage_valid <= 1'b0;
         stage_op <= NABC_ADD_OP;
         temp_a <= 4'h0;
         temp_b <= 4'h0;
         stage_first_mem <= 1'b0;
         stage_addr <= '0;
      end else begin
         stage_valid <= next_stage_valid;
         stage_op <= next_stage_op;
         temp_a <= next_temp_a;
         temp_b <= next_temp_b;
         stage_first_mem <= next_stage_first_mem;
         stage_addr <= next_stage_addr;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Avalon slave: one wait cycle, then answer

   logic        ack;
   logic        next_ack;
   logic [31:0] rdata;
   logic [31:0] next_rdata;
   logic        bus_req;
   logic        bus_wr_status;
   logic [5:0]  last_res;

   assign bus_req = AVS_READ | AVS_WRITE;
   assign AVS_WAITREQUEST = bus_req & ~ack;
   assign AVS_READDATA = rdata;
   assign bus_wr_status = AVS_WRITE && ack && AVS_BYTEENABLE[0] &&
                          (AVS_ADDRESS == STATUS_WORD_OFS);

   always_comb begin
      next_ack = bus_req & ~ack;
      next_rdata = rdata;
      if (AVS_READ && !ack) begin
         if (AVS_ADDRESS == STATUS_WORD_OFS) begin
            next_rdata = {27'h0000000, flags};
         end else if (AVS_ADDRESS == RESULT_OFS) begin
            next_rdata = {26'h0000000, last_res};
         end else begin
            next_rdata = 32'h00000000;
         end
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         ack <= 1'b0;
         rdata <= 32'h00000000;
      end else begin
         ack <= next_ack;
         rdata <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Execute stage and status flip-flop

   logic [4:0]            raw_sum;
   logic [4:0]            raw_dif;
   logic [4:0]            judge_dif;
   logic [4:0]            arith;
   logic                  cin;
   logic                  is_add;
   logic                  is_sub;
   logic                  is_arith;
   logic                  is_logic;
   logic                  is_bit;
   logic                  is_judge;
   logic                  is_rot;
   logic                  do_store;
   logic [NIB_W-1:0]      res;
   logic                  skip;
   logic [FLAG_W-1:0]     next_flags;
   logic                  next_wb_reg_we;
   logic                  next_wb_mem_we;
   logic [NIB_W-1:0]      next_wb_data;
   logic [MEM_ADDR_W-1:0] next_wb_mem_addr;
   logic                  next_skip_next;
   logic                  next_op_done;
   logic [5:0]            next_last_res;

   always_comb begin
      is_add = (stage_op == NABC_ADD_OP) || (stage_op == ADD_WITH_CARRY_OP);
      is_sub = (stage_op == NABC_SUBTRACT_OP) || (stage_op == DIFFERENCE_WITH_BORROW_OP);
      is_arith = is_add || is_sub;
      is_logic = (stage_op == NABC_OR_OP) || (stage_op == NABC_AND_OP) ||
                 (stage_op == NABC_XOR_OP);
      is_bit = (stage_op == SKIP_IF_BITS_SET) || (stage_op == SKIP_IF_BITS_CLEAR);
      is_judge = (stage_op == SKIP_IF_EQUAL) || (stage_op == SKIP_IF_UNEQUAL) ||
               (stage_op == SKIP_IF_GREATER_EQUAL) || (stage_op == SKIP_IF_LESS);
      is_rot = (stage_op == ROTATE_RIGHT_THROUGH_CARRY);
      // Carry variants take the live flag as the least significant input
      cin = ((stage_op == ADD_WITH_CARRY_OP) || (stage_op == DIFFERENCE_WITH_BORROW_OP)) &&
            flags[CARRY_BIT];
      raw_sum = {1'b0, temp_a} + {1'b0, temp_b} + {4'h0, cin};
      raw_dif = {1'b0, temp_a} - {1'b0, temp_b} - {4'h0, cin};
      judge_dif = {1'b0, temp_a} - {1'b0, temp_b};
      if (flags[BCD_BIT]) begin
         arith = is_add ? dec_add_fix(raw_sum) : dec_sub_fix(raw_dif);
      end else begin
         arith = is_add ? raw_sum : raw_dif;
      end
      res = temp_a;
      skip = 1'b0;
      case (stage_op)
         NABC_OR_OP: res = temp_a | temp_b;
         NABC_AND_OP: res = temp_a & temp_b;
         NABC_XOR_OP: res = temp_a ^ temp_b;
         SKIP_IF_BITS_SET: skip = ((temp_a & temp_b) == temp_b);
         SKIP_IF_BITS_CLEAR: skip = ((temp_a & temp_b) == 4'h0);
         SKIP_IF_EQUAL: skip = (judge_dif[3:0] == 4'h0);
         SKIP_IF_UNEQUAL: skip = (judge_dif[3:0] != 4'h0);
         SKIP_IF_GREATER_EQUAL: skip = !judge_dif[4];
         SKIP_IF_LESS: skip = judge_dif[4];
         ROTATE_RIGHT_THROUGH_CARRY: res = {flags[CARRY_BIT], temp_a[3:1]};
         default: res = arith[3:0];
      endcase
      // Compare mode and decimal mode never reach the non-arithmetic paths
      do_store = stage_valid && (is_logic || is_rot ||
                 (is_arith && !flags[COMPARE_BIT]));

      // Bus write lands first; an instruction's own update wins a same-cycle clash
      next_flags = flags;
      if (bus_wr_status) begin
         next_flags = AVS_WRITEDATA[FLAG_W-1:0];
      end
      if (stage_valid && is_arith) begin
         next_flags[CARRY_BIT] = arith[4];
         if (flags[COMPARE_BIT]) begin
            next_flags[ZERO_BIT] = flags[ZERO_BIT] && (arith[3:0] == 4'h0);
         end else begin
            next_flags[ZERO_BIT] = (arith[3:0] == 4'h0);
         end
      end
      if (stage_valid && is_rot) begin
         next_flags[CARRY_BIT] = temp_a[0];
      end
      if (stage_valid && is_bit) begin
         next_flags[COMPARE_BIT] = 1'b0;
      end

      next_wb_reg_we = do_store && !stage_first_mem;
      next_wb_mem_we = do_store && stage_first_mem;
      next_wb_data = do_store ? res : WB_DATA;
      next_wb_mem_addr = stage_valid ? stage_addr : WB_MEM_ADDR;
      next_skip_next = stage_valid && (is_bit || is_judge) && skip;
      next_op_done = stage_valid;
      next_last_res = last_res;
      if (stage_valid) begin
         next_last_res = {next_flags[CARRY_BIT], next_skip_next, res};
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         flags <= STATUS_WORD_RST;
         WB_REG_WE <= 1'b0;
         WB_MEM_WE <= 1'b0;
         WB_DATA <= 4'h0;
         WB_MEM_ADDR <= '0;
         SKIP_NEXT <= 1'b0;
         OP_DONE <= 1'b0;
         last_res <= RESULT_RST;
      end else begin
         flags <= next_flags;
         WB_REG_WE <= next_wb_reg_we;
         WB_MEM_WE <= next_wb_mem_we;
         WB_DATA <= next_wb_data;
         WB_MEM_ADDR <= next_wb_mem_addr;
         SKIP_NEXT <= next_skip_next;
         OP_DONE <= next_op_done;
         last_res <= next_last_res;
      end
   end

   assign STATUS_FLAGS = flags;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (!RST_N);

   sequence s_issue;
      OP_VALID ##1 stage_valid;
   endsequence

   sequence s_arith_in_compare;
      stage_valid && is_arith && flags[COMPARE_BIT];
   endsequence

   chk_operand_latch: assert property (
      OP_VALID |-> ##1 (temp_a == $past(OPERAND_FIRST)) && (temp_b == $past(OPERAND_SECOND)))
      else $error("operands not latched into temporaries");

   chk_compare_no_store: assert property (
      s_arith_in_compare |=> !WB_REG_WE && !WB_MEM_WE && OP_DONE)
      else $error("arithmetic result stored in compare mode");

   chk_bit_test_clear: assert property (
      s_issue ##0 is_bit |=> !flags[COMPARE_BIT] && OP_DONE)
      else $error("bit test left compare mode set");

   chk_logic_flags: assert property (
      stage_valid && is_logic && !bus_wr_status |=>
         $stable(flags) && !SKIP_NEXT && (WB_REG_WE || WB_MEM_WE))
      else $error("logic op touched flags or skipped store");

   chk_rotate_data: assert property (
      stage_valid && is_rot |=> WB_REG_WE &&
         (WB_DATA == {$past(flags[CARRY_BIT]), $past(temp_a[3:1])}) &&
         (flags[CARRY_BIT] == $past(temp_a[0])))
      else $error("rotate through carry wrong");

   chk_dec_add_teens: assert property (
      stage_valid && is_add && flags[BCD_BIT] && (raw_sum >= DEC_TEN) &&
         (raw_sum < DEC_TWENTY) |=>
         flags[CARRY_BIT] && (last_res[3:0] == 4'($past(raw_sum) - DEC_TEN)))
      else $error("decimal sum 10 to 19 wrong");

   chk_zero_accum: assert property (
      s_arith_in_compare ##0 (arith[3:0] != 4'h0) |=> !flags[ZERO_BIT])
      else $error("compare mode zero not cleared");

   chk_bin_carry: assert property (
      stage_valid && is_arith && !flags[BCD_BIT] |=>
         flags[CARRY_BIT] == $past(raw_sum[4] & is_add | raw_dif[4] & is_sub))
      else $error("binary carry wrong");

   chk_bus_mirror: assert property (
      bus_wr_status && !stage_valid |=> flags == $past(AVS_WRITEDATA[FLAG_W-1:0]))
      else $error("status word write not mirrored");

   chk_dec_range: assert property (
      stage_valid && is_add && flags[BCD_BIT] && (raw_sum >= DEC_TWENTY) |=>
         last_res[3:0] >= 4'hA && flags[CARRY_BIT])
      else $error("out of range decimal result below 1010");

endmodule : nabc_alu

`default_nettype wire

/* File: tb/nabc_far_model.sv */
// Register file and data memory model fed by the write-back port
`timescale 1ns/1ns
`default_nettype none
module nabc_far_model #(
   parameter int AW = 7
) (
   input wire logic          clk,
   input wire logic          reg_we,
   input wire logic          mem_we,
   input wire logic [3:0]    data,
   input wire logic [AW-1:0] addr
);
   logic [3:0] gen_reg;
   logic [3:0] mem [2**AW];
   int         wr_cnt = 0;
   // Stores only on a pulse, so a missing gate shows as extra writes
   always @(posedge clk) begin
      if (reg_we)
         gen_reg <= data;
      if (mem_we)
         mem[addr] <= data;
      if (reg_we || mem_we)
         wr_cnt <= wr_cnt + 1;
   end
endmodule : nabc_far_model
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the nibble ALU
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import nabc_pkg::*;
   localparam int AW = 7;
   logic          SYS_CLK, RST_N, OP_VALID, FIRST_IS_MEM, AVS_READ, AVS_WRITE;
   nabc_op_t      OP_CODE;
   logic [3:0]    OPERAND_FIRST, OPERAND_SECOND, AVS_ADDRESS, AVS_BYTEENABLE, WB_DATA;
   logic [AW-1:0] MEM_ADDR_IN, INDEX_IN, WB_MEM_ADDR, ad;
   logic          WB_REG_WE, WB_MEM_WE, SKIP_NEXT, OP_DONE, AVS_WAITREQUEST;
   logic [4:0]    STATUS_FLAGS, r;
   logic [31:0]   AVS_WRITEDATA, AVS_READDATA, rd;
   logic [3:0]    a, b;
   logic [1:0]    k;
   logic          c, carry_acc, z, exz;
   logic          sk [6];
   int            error_cnt = 0, checks_done = 0, cyc = 0, wc;
   nabc_alu #(.MEM_ADDR_W(AW)) nabc_alu_inst (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
      .OP_VALID(OP_VALID), .OP_CODE(OP_CODE), .OPERAND_FIRST(OPERAND_FIRST),
      .OPERAND_SECOND(OPERAND_SECOND), .FIRST_IS_MEM(FIRST_IS_MEM),
      .MEM_ADDR_IN(MEM_ADDR_IN), .INDEX_IN(INDEX_IN), .WB_REG_WE(WB_REG_WE),
      .WB_MEM_WE(WB_MEM_WE), .WB_DATA(WB_DATA), .WB_MEM_ADDR(WB_MEM_ADDR),
      .SKIP_NEXT(SKIP_NEXT), .OP_DONE(OP_DONE), .STATUS_FLAGS(STATUS_FLAGS),
      .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
      .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
      .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST));
   nabc_far_model #(.AW(AW)) nabc_far_model_inst (.clk(SYS_CLK), .reg_we(WB_REG_WE),
      .mem_we(WB_MEM_WE), .data(WB_DATA), .addr(WB_MEM_ADDR));
   ////////////////////////////////////////////////////////////////
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : print_verdict
   task automatic chk(input string nm, input logic [31:0] s, e);
      checks_done++;
      if (s !== e) begin
         error_cnt++;
         $display("wrong value %s exp %0h seen %0h", nm, e, s);
      end
   endtask : chk
   // Holds the request until waitrequest is seen low at an edge
   task automatic av(input logic wr, input logic [3:0] ad4, input logic [31:0] d,
                     input logic [3:0] be);
      @(posedge SYS_CLK);
      AVS_ADDRESS <= ad4;
      AVS_WRITEDATA <= d;
      AVS_BYTEENABLE <= be;
      AVS_WRITE <= wr;
      AVS_READ <= !wr;
      @(posedge SYS_CLK);
      while (AVS_WAITREQUEST !== 1'b0)
         @(posedge SYS_CLK);
      rd = AVS_READDATA;
      AVS_WRITE <= 0;
      AVS_READ <= 0;
   endtask : av
   // One issue cycle, answer looked at just after the second edge that follows it
   task automatic op(input nabc_op_t o, input logic [3:0] x, y, input logic m);
      @(posedge SYS_CLK);
      OP_VALID <= 1;
      OP_CODE <= o;
      OPERAND_FIRST <= x;
      OPERAND_SECOND <= y;
      FIRST_IS_MEM <= m;
      MEM_ADDR_IN <= {x, y[2:0]};
      @(posedge SYS_CLK);
      OP_VALID <= 0;
      @(posedge SYS_CLK);
      #1;
      chk("done", OP_DONE, 1);
   endtask : op
   function automatic logic [4:0] ref_ar(input logic sub, bcd, input logic [3:0] x, y,
                                         input logic ci);
      int s;
      s = sub ? int'(x) - int'(y) - int'(ci) : int'(x) + int'(y) + int'(ci);
      if (!bcd)
         return {s < 0 || s > 15, 4'(s)};
      if (s >= 0 && s <= 9)
         return {1'b0, 4'(s)};
      if (!sub && s < 20)
         return {1'b1, 4'(s - 10)};
      if (!sub && s >= 28)
         return {1'b1, 4'(s - 18)};
      if (!sub || s > 9)
         return {1'b1, 2'h3, 2'(s - 18)};
      if (s >= -10)
         return {1'b1, 4'(s + 10)};
      return {1'b1, 2'h3, 2'(s + 18)};
   endfunction : ref_ar
   ////////////////////////////////////////////////////////////////
   initial begin
      SYS_CLK = 0;
      forever #20 SYS_CLK = ~SYS_CLK;
   end
   // Whole run is about 24k cycles
   always @(posedge SYS_CLK) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         error_cnt++;
         print_verdict();
      end
   end
   initial begin
      {RST_N, OP_VALID, FIRST_IS_MEM, AVS_READ, AVS_WRITE} = '0;
      {OPERAND_FIRST, OPERAND_SECOND, AVS_ADDRESS, AVS_BYTEENABLE} = '0;
      OP_CODE = NABC_ADD_OP;
      MEM_ADDR_IN = '0;
      INDEX_IN = 7'h55;
      AVS_WRITEDATA = '0;
      repeat (5) @(posedge SYS_CLK);
      RST_N <= 1;
      av(0, STATUS_WORD_OFS, 0, 4'hF);
      chk("status_rst", rd, 0);
      av(0, RESULT_OFS, 0, 4'hF);
      chk("result_rst", rd, 0);
      av(1, 4'h8, 32'h1F, 4'hF);
      av(0, 4'h8, 0, 4'hF);
      chk("unmapped", rd, 0);
      av(1, STATUS_WORD_OFS, 32'h1F, 4'h0);
      av(0, STATUS_WORD_OFS, 0, 4'hF);
      chk("be_off", rd, 0);
      av(1, STATUS_WORD_OFS, 32'h1F, 4'hF);
      @(posedge SYS_CLK);
      #1;
      chk("flags_wr", STATUS_FLAGS, 5'h1F);
      $display("test registers done");
      for (int md = 0; md < 4; md++) begin
         av(1, STATUS_WORD_OFS, {27'h0, md[1], md[0], 1'b0, 1'b1, md[1]}, 4'hF);
         carry_acc = 0;
         z = 1;
         wc = nabc_far_model_inst.wr_cnt;
         for (int i = 0; i < 1024; i++) begin
            a = i[3:0];
            b = i[7:4];
            k = i[9:8];
            ad = {a, b[2:0]};
            r = ref_ar(k[1], md[1], a, b, k[0] & carry_acc);
            exz = (r[3:0] == 0) ? (md[0] ? z : 1'b1) : 1'b0;
            op(nabc_op_t'(k), a, b, a[0]);
            if (!md[0])
               chk("data", WB_DATA, r[3:0]);
            chk("reg_we", WB_REG_WE, !md[0] && !a[0]);
            chk("mem_we", WB_MEM_WE, !md[0] && a[0]);
            chk("flags", STATUS_FLAGS, {md[1], md[0], r[4], exz, md[1]});
            if (a[0])
               chk("addr", WB_MEM_ADDR, md[1] ? 7'(ad + 7'h55) : ad);
            carry_acc = r[4];
            z = exz;
         end
         @(posedge SYS_CLK);
         #1;
         chk("writes", nabc_far_model_inst.wr_cnt - wc, md[0] ? 0 : 1024);
      end
      $display("test arithmetic done");
      av(1, STATUS_WORD_OFS, 32'h1E, 4'hF);
      for (int i = 0; i < 768; i++) begin
         a = i[3:0];
         b = i[7:4];
         k = i[9:8];
         op(nabc_op_t'(4 + k), a, b, a[0]);
         chk("logic", WB_DATA, k == 0 ? a | b : k == 1 ? a & b : a ^ b);
         chk("logic_we", WB_REG_WE, !a[0]);
         chk("logic_flags", STATUS_FLAGS, 5'h1E);
      end
      $display("test logic done");
      // Last logic store lands one edge after its check
      @(posedge SYS_CLK);
      #1;
      chk("mem", nabc_far_model_inst.mem[7'h7F], 4'h0);
      wc = nabc_far_model_inst.wr_cnt;
      for (int i = 0; i < 1536; i++) begin
         a = i[3:0];
         b = i[7:4];
         sk = '{(a & b) == b, (a & b) == 0, a == b, a != b, a >= b, a < b};
         av(1, STATUS_WORD_OFS, 32'h1E, 4'hF);
         op(nabc_op_t'(7 + i / 256), a, b, 1);
         chk("skip", SKIP_NEXT, sk[i / 256]);
         chk("test_flags", STATUS_FLAGS, i < 512 ? 5'h16 : 5'h1E);
      end
      @(posedge SYS_CLK);
      #1;
      chk("test_writes", nabc_far_model_inst.wr_cnt - wc, 0);
      $display("test judgements done");
      for (int i = 0; i < 32; i++) begin
         a = i[3:0];
         c = i[4];
         av(1, STATUS_WORD_OFS, {27'h0, 2'h3, c, 2'h0}, 4'hF);
         op(ROTATE_RIGHT_THROUGH_CARRY, a, 4'h0, 0);
         chk("rot", WB_DATA, {c, a[3:1]});
         chk("rot_we", WB_REG_WE, 1);
         chk("rot_flags", STATUS_FLAGS, {2'h3, a[0], 2'h0});
      end
      @(posedge SYS_CLK);
      #1;
      chk("gen_reg", nabc_far_model_inst.gen_reg, 4'hF);
      av(1, RESULT_OFS, 32'h0, 4'hF);
      av(0, RESULT_OFS, 0, 4'hF);
      chk("result", rd, 32'h2F);
      $display("test rotate done");
      av(1, STATUS_WORD_OFS, 32'h0, 4'hF);
      @(posedge SYS_CLK);
      OP_VALID <= 1;
      OP_CODE <= NABC_ADD_OP;
      OPERAND_FIRST <= 4'h9;
      OPERAND_SECOND <= 4'h8;
      FIRST_IS_MEM <= 0;
      @(posedge SYS_CLK);
      OP_CODE <= ADD_WITH_CARRY_OP;
      OPERAND_FIRST <= 4'h0;
      OPERAND_SECOND <= 4'h0;
      @(posedge SYS_CLK);
      OP_VALID <= 0;
      #1;
      chk("chain1", WB_DATA, 4'h1);
      @(posedge SYS_CLK);
      #1;
      chk("chain2", WB_DATA, 4'h1);
      chk("chain_cy", STATUS_FLAGS, 5'h0);
      $display("test chain done");
      print_verdict();
   end
endmodule : tb_top
`default_nettype wire
